// >>> ohcr_regs.svh
// Purpose: Constants for the one hertz clock regenerator
// Assumes: Timer clock is the bus clock, 512 times the 32768 Hz crystal
// Notes: Counts derived from times are computed here, not hand-entered
//
// How it works
// - The regenerated clock spreads the correction N/(32768*M) seconds over every second.
// - The timer runs from a bus clock of 512 times the shared 32768 Hz crystal.
// - Per-second correction in bus cycles is 512 times N divided by M.
// - Each interval is aligned to its first edge, the last edge of one being the next's first.
// - Rising or falling pulse edge is selectable as the alignment edge.
// - Two channels: one captures the pulse, the other drives the regenerated clock.
// - On the selected edge the counter is latched into the capture value and an event raised.
// - After a capture the output channel compares against the capture value plus a shift.
// - The regenerated clock has equal periods and about half duty.
// - Match sets the pin and an event, clears it half a second later at prescale 128, then 1.
`ifndef OHCR_REGS_SVH
`define OHCR_REGS_SVH

`define OHCR_XTAL_HZ 32768
`define OHCR_BUS_MULT 512
`define OHCR_BUS_HZ (`OHCR_XTAL_HZ * `OHCR_BUS_MULT)
`define OHCR_PRESC_SLOW 128
`define OHCR_HIGH_TIME_MS 500
// Slow ticks in the high half second; divide first so the product stays in 32 bits
`define OHCR_HIGH_TICKS (((`OHCR_BUS_HZ / `OHCR_PRESC_SLOW) * `OHCR_HIGH_TIME_MS) / 1000)
`define OHCR_CNT_RST 16'h0000
`define OHCR_CMP_RST 16'h0000
`define OHCR_CAP_RST 16'h0000
`define OHCR_IDX_RST 8'h00
`define OHCR_NSHIFT 9

`endif

// >>> ohcr_pkg.sv
// Purpose: Types for the one hertz clock regenerator
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Output channel states only
package ohcr_pkg;

    typedef enum logic [1:0] {
        OHCR_IDLE  = 2'b00,
        OHCR_ARMED = 2'b01,
        OHCR_HIGH  = 2'b10
    } ohcr_state_e;

endpackage

// >>> ohcr_top.sv
// Purpose: Regenerate an evenly spaced 1 Hz clock from the compensated pulse of the time keeper
// Assumes: clk is the timer bus clock; pulse and done flag arrive asynchronously
// Notes: Compensation setting and delay are plain inputs held by software
`timescale 1ns/10ps
`include "ohcr_regs.svh"

module ohcr_top
    import ohcr_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int HIGH_TICKS = `OHCR_HIGH_TICKS
) (
    input wire logic clk, // Timer bus clock
    input wire logic reset, // Synchronous, active high
    input wire logic rtc_pulse_output, // Compensated pulse from time keeper
    input wire logic compensation_done_flag, // Interval nearly complete
    input wire logic edge_sel_fall, // 1 aligns on falling edge
    input wire logic [7:0] comp_interval, // M, seconds
    input wire logic signed [7:0] comp_value, // N, crystal cycles
    input wire logic [CNT_W-1:0] shift_delay, // Fixed delay constant
    output logic clk_1hz_out, // Regenerated 1 Hz clock
    output logic [CNT_W-1:0] capture_value_reg, // Counter at last capture
    output logic [CNT_W-1:0] compare_value_reg, // Output channel compare
    output logic capture_irq, // Capture event pulse
    output logic compare_irq, // Output set event pulse
    output logic presc_slow, // Prescale 128 active
    output logic [7:0] second_index // Second within interval
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CNT_W != 16) begin : g_bad_width
        $error("ohcr_top: counter must be 16 bits");
    end
    if (HIGH_TICKS < 1 || HIGH_TICKS > 131071) begin : g_bad_high
        $error("ohcr_top: HIGH_TICKS out of range");
    end

    // ****************************************************************
    // Shift for one second of the interval
    // ****************************************************************
    // phi = delay - (M-k)*512*N/M for k>0, delay for k=0
    function automatic logic [CNT_W-1:0] calc_phi(
        input logic [7:0] k,
        input logic [7:0] m,
        input logic signed [7:0] n,
        input logic [CNT_W-1:0] sigma
    );
        logic signed [17:0] n512;
        logic signed [26:0] prod;
        logic signed [26:0] quot;
        logic signed [26:0] adj;
        n512 = 18'(n) <<< `OHCR_NSHIFT;
        prod = 27'($signed({1'b0, k})) * 27'(n512);
        quot = 27'(prod / $signed({1'b0, m}));
        adj = quot - 27'(n512);
        if (k == `OHCR_IDX_RST || m == `OHCR_IDX_RST || n == 8'sh00) begin
            calc_phi = sigma;
        end else begin
            calc_phi = sigma + adj[CNT_W-1:0];
        end
    endfunction

    // ****************************************************************
    // Input synchronisers and edge select
    // ****************************************************************
    logic pulse_s1_ff;
    logic pulse_s2_ff;
    logic pulse_s3_ff;
    logic done_s1_ff;
    logic done_s2_ff;
    logic cap_edge;

    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_s1_ff <= 1'b0;
            pulse_s2_ff <= 1'b0;
            pulse_s3_ff <= 1'b0;
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
        end else begin
            pulse_s1_ff <= rtc_pulse_output;
            pulse_s2_ff <= pulse_s1_ff;
            pulse_s3_ff <= pulse_s2_ff;
            done_s1_ff <= compensation_done_flag;
            done_s2_ff <= done_s1_ff;
        end
    end

    assign cap_edge = edge_sel_fall ? (pulse_s3_ff && !pulse_s2_ff)
                                    : (!pulse_s3_ff && pulse_s2_ff);

    // ****************************************************************
    // Prescaler and free-running counter
    // ****************************************************************
    logic [6:0] div_ff;
    logic presc_slow_ff;
    logic tick;
    logic [CNT_W-1:0] count_ff;

    // Only the high half second runs slow, so captures outside it see full resolution
    assign tick = !presc_slow_ff || (div_ff == 7'(`OHCR_PRESC_SLOW - 1));

    always_ff @(posedge clk) begin
        if (reset) begin
            div_ff <= 7'h00;
        end else if (!presc_slow_ff || tick) begin
            div_ff <= 7'h00;
        end else begin
            div_ff <= div_ff + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_ff <= `OHCR_CNT_RST;
        end else if (tick) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // ****************************************************************
    // Capture channel
    // ****************************************************************
    logic [CNT_W-1:0] capture_ff;
    logic capture_irq_ff;
    logic start_pending_ff;
    logic [7:0] index_ff;
    logic [7:0] cur_index;

    always_ff @(posedge clk) begin
        if (reset) begin
            capture_ff <= `OHCR_CAP_RST;
            capture_irq_ff <= 1'b0;
        end else begin
            capture_irq_ff <= cap_edge;
            if (cap_edge) begin
                capture_ff <= count_ff;
            end
        end
    end

    // Done flag arms a restart; a set in the capture cycle wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            start_pending_ff <= 1'b1;
        end else if (done_s2_ff) begin
            start_pending_ff <= 1'b1;
        end else if (cap_edge) begin
            start_pending_ff <= 1'b0;
        end
    end

    assign cur_index = start_pending_ff ? `OHCR_IDX_RST : index_ff;

    // Index saturates so a lost done flag cannot wrap the shift
    always_ff @(posedge clk) begin
        if (reset) begin
            index_ff <= `OHCR_IDX_RST;
        end else if (cap_edge && cur_index != 8'hFF) begin
            index_ff <= cur_index + 8'h01;
        end
    end

    // ****************************************************************
    // Output compare channel
    // ****************************************************************
    ohcr_state_e state_ff;
    logic [CNT_W-1:0] compare_ff;
    logic [16:0] high_cnt_ff;
    logic clk_out_ff;
    logic compare_irq_ff;
    logic match;
    logic high_done;
    logic rearm_ff;

    assign match = (count_ff == compare_ff);
    assign high_done = tick && (high_cnt_ff == 17'(HIGH_TICKS - 1));

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= OHCR_IDLE;
        end else begin
            case (state_ff)
                OHCR_IDLE: begin
                    if (cap_edge) begin
                        state_ff <= OHCR_ARMED;
                    end
                end
                OHCR_ARMED: begin
                    if (cap_edge) begin
                        state_ff <= OHCR_ARMED;
                    end else if (match) begin
                        state_ff <= OHCR_HIGH;
                    end
                end
                OHCR_HIGH: begin
                    if (high_done) begin
                        state_ff <= (cap_edge || rearm_ff) ? OHCR_ARMED : OHCR_IDLE;
                    end
                end
                default: begin
                    state_ff <= OHCR_IDLE;
                end
            endcase
        end
    end

    // A capture in the high phase must not be lost when the phase ends
    always_ff @(posedge clk) begin
        if (reset) begin
            rearm_ff <= 1'b0;
        end else if (state_ff != OHCR_HIGH) begin
            rearm_ff <= 1'b0;
        end else if (cap_edge) begin
            rearm_ff <= 1'b1;
        end
    end

    // Compare tracks each capture plus its own shift
    always_ff @(posedge clk) begin
        if (reset) begin
            compare_ff <= `OHCR_CMP_RST;
        end else if (cap_edge) begin
            compare_ff <= count_ff + calc_phi(cur_index, comp_interval,
                                              comp_value, shift_delay);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            high_cnt_ff <= 17'h00000;
        end else if (state_ff != OHCR_HIGH) begin
            high_cnt_ff <= 17'h00000;
        end else if (tick) begin
            high_cnt_ff <= high_cnt_ff + 17'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            clk_out_ff <= 1'b0;
            presc_slow_ff <= 1'b0;
            compare_irq_ff <= 1'b0;
        end else begin
            compare_irq_ff <= 1'b0;
            if (state_ff == OHCR_ARMED && !cap_edge && match) begin
                clk_out_ff <= 1'b1;
                presc_slow_ff <= 1'b1;
                compare_irq_ff <= 1'b1;
            end else if (state_ff == OHCR_HIGH && high_done) begin
                clk_out_ff <= 1'b0;
                presc_slow_ff <= 1'b0;
            end
        end
    end

    assign clk_1hz_out = clk_out_ff;
    assign capture_value_reg = capture_ff;
    assign compare_value_reg = compare_ff;
    assign capture_irq = capture_irq_ff;
    assign compare_irq = compare_irq_ff;
    assign presc_slow = presc_slow_ff;
    assign second_index = index_ff;

endmodule // ohcr_top

// >>> ohcr_top_sva.sv
// Purpose: Port checks of the 1 Hz regenerator
// Assumes: Pulses at least 16 clocks wide
// Notes: Bound to ohcr_top below
`timescale 1ns/10ps
module ohcr_top_sva
    import ohcr_pkg::*;
#(
    parameter int HIGH_TICKS = 4
) (
    input wire logic clk, // Bus clock
    input wire logic reset, // Sync reset
    input wire logic rtc_pulse_output, // Pulse in
    input wire logic edge_sel_fall, // Edge select
    input wire logic [15:0] shift_delay, // Sigma
    input wire logic clk_1hz_out, // Out clock
    input wire logic [15:0] capture_value_reg, // Capture
    input wire logic [15:0] compare_value_reg, // Compare
    input wire logic capture_irq, // Capture event
    input wire logic compare_irq, // Set event
    input wire logic presc_slow, // Slow prescale
    input wire logic [7:0] second_index // Second index
);
    // ****
    // Checks
    // ****
    logic [31:0] high_cnt_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // The divider is hidden, so the high time is counted here
    always_ff @(posedge clk) begin
        high_cnt_ff <= clk_1hz_out ? high_cnt_ff + 32'h00000001 : 32'h00000000;
    end
    sequence s_set_phase;
        clk_1hz_out && presc_slow && compare_irq;
    endsequence
    a_rise_capture: assert property ($rose(rtc_pulse_output) && !edge_sel_fall
        |-> ##[3:4] capture_irq) else $error("no capture on rise");
    a_fall_capture: assert property ($fell(rtc_pulse_output) && edge_sel_fall
        |-> ##[3:4] capture_irq) else $error("no capture on fall");
    a_capture_single: assert property (capture_irq |=> !capture_irq)
        else $error("capture event too long");
    a_set_single: assert property (compare_irq |=> !compare_irq)
        else $error("set event too long");
    a_set_phase: assert property ($rose(clk_1hz_out) |-> s_set_phase)
        else $error("set phase incomplete");
    a_high_width: assert property ($fell(clk_1hz_out)
        |-> high_cnt_ff == 32'(128 * HIGH_TICKS)) else $error("bad high time");
    a_presc_level: assert property (presc_slow == clk_1hz_out)
        else $error("prescale not tied to output");
    a_first_shift: assert property (capture_irq && second_index == 8'h01
        |-> compare_value_reg == capture_value_reg + shift_delay) else $error("bad shift");
    a_capture_hold: assert property (!capture_irq |-> $stable(capture_value_reg)
        && $stable(compare_value_reg)) else $error("value moved without capture");
endmodule // ohcr_top_sva
bind ohcr_top ohcr_top_sva #(.HIGH_TICKS(HIGH_TICKS)) chk_u (.clk(clk), .reset(reset),
    .rtc_pulse_output(rtc_pulse_output), .edge_sel_fall(edge_sel_fall),
    .shift_delay(shift_delay), .clk_1hz_out(clk_1hz_out), .presc_slow(presc_slow),
    .capture_value_reg(capture_value_reg), .compare_value_reg(compare_value_reg),
    .capture_irq(capture_irq), .compare_irq(compare_irq), .second_index(second_index));

// >>> ohcr_rtc_model.sv
// Purpose: Time keeper pulse source
// Assumes: One second scaled to SEC_CLK bus clocks
// Notes: Correction of 512 clocks per unit of N
`timescale 1ns/10ps
module ohcr_rtc_model #(
    parameter int SEC_CLK = 2000
) (
    input wire logic clk, // Bus clock
    input wire logic reset, // Sync reset
    input wire logic [7:0] comp_interval, // M
    input wire logic signed [7:0] comp_value, // N
    output logic rtc_pulse_output, // Pulse out
    output logic compensation_done_flag // Interval ending
);
    // ****
    // Pulse train
    // ****
    int cnt;
    int sec;
    int len;
    // All correction sits in the first second
    assign len = (sec == 0) ? SEC_CLK + 512 * int'(comp_value) : SEC_CLK;
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= 0;
            sec <= 0;
            rtc_pulse_output <= 1'b0;
            compensation_done_flag <= 1'b0;
        end else begin
            cnt <= (cnt == len - 1) ? 0 : cnt + 1;
            if (cnt == len - 1) begin
                sec <= (sec + 1 == int'(comp_interval)) ? 0 : sec + 1;
            end
            rtc_pulse_output <= (cnt < 16);
            // Short flag mid last second, gone before the next edge
            compensation_done_flag <= (sec == int'(comp_interval) - 1)
                && (cnt >= SEC_CLK / 2) && (cnt < SEC_CLK / 2 + 8);
        end
    end
endmodule // ohcr_rtc_model

// >>> ohcr_top_tb_top.sv
// Purpose: Self-checking bench of the 1 Hz regenerator
// Assumes: HIGH_TICKS 4, second scaled to 2000 clocks
// Notes: Inputs change by non-blocking assignment at the edge
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module ohcr_top_tb_top;
    import ohcr_pkg::*;
    // ****
    // Bench
    // ****
    localparam int SEC = 2000;
    localparam int M = 4;
    localparam int N = -2;
    // Large enough that every shift stays above zero for both settings used
    localparam logic [15:0] SIGMA = 16'h0040;
    logic [7:0] m_set = 8'(M);
    logic signed [7:0] n_set = 8'(N);
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic edge_sel_fall = 1'b0;
    logic pulse;
    logic done;
    logic out;
    logic cap_irq;
    logic [15:0] cap;
    logic [15:0] cmp;
    logic [7:0] idx;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    ohcr_top #(.HIGH_TICKS(4)) dut_u (.clk(clk), .reset(reset), .rtc_pulse_output(pulse),
        .compensation_done_flag(done), .edge_sel_fall(edge_sel_fall), .comp_interval(m_set),
        .comp_value(n_set), .shift_delay(SIGMA), .clk_1hz_out(out), .capture_value_reg(cap),
        .compare_value_reg(cmp), .capture_irq(cap_irq), .compare_irq(), .presc_slow(),
        .second_index(idx));
    ohcr_rtc_model #(.SEC_CLK(SEC)) far_u (.clk(clk), .reset(reset), .comp_interval(m_set),
        .comp_value(n_set), .rtc_pulse_output(pulse), .compensation_done_flag(done));
    // Shift for second k of an interval of m seconds with value n
    function automatic int exp_phi(input int k, input int m, input int n);
        if (k == 0 || m == 0 || n == 0) begin
            exp_phi = int'(SIGMA);
        end else begin
            exp_phi = int'(SIGMA) - 512 * n + (k * 512 * n) / m;
        end
    endfunction
    task automatic close_out();
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 40000) begin
            fails++;
            close_out();
        end
    end
    task automatic do_reset(input logic fall);
        reset <= 1'b1;
        edge_sel_fall <= fall;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
    endtask
    // Which 0 waits on the capture event, 1 on the output level
    task automatic wait_sig(input int which, input logic lvl);
        int n;
        n = 0;
        @(posedge clk);
        while (((which == 0) ? cap_irq : out) !== lvl && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            fails++;
            $display("Error wait expected %0h seen %0h", lvl, ((which == 0) ? cap_irq : out));
        end
    endtask
    task automatic test_captures();
        int k;
        int phi;
        for (int i = 0; i < 6; i++) begin
            wait_sig(0, 1'b1);
            k = i % M;
            phi = (k == 0) ? int'(SIGMA) : int'(SIGMA) - 512 * N + (k * 512 * N) / M;
            `CHK("compare", cap + phi[15:0], cmp)
            `CHK("second", 8'(k + 1), idx)
            `CHK("edge level", 1'b1, pulse)
        end
    endtask
    task automatic test_output();
        time t;
        wait_sig(1, 1'b1);
        t = $time;
        for (int i = 0; i < 5; i++) begin
            wait_sig(1, 1'b0);
            `CHK("high time", 512, int'(($time - t) / 50))
            wait_sig(1, 1'b1);
            `CHK("period", SEC + 512 * N / M, int'(($time - t) / 50))
            t = $time;
        end
    endtask
    // Reset in mid-run with a new setting, then align on the falling edge
    task automatic test_fall();
        m_set <= 8'h03;
        n_set <= 8'hFD;
        do_reset(1'b1);
        wait_sig(0, 1'b1);
        `CHK("fall level", 1'b0, pulse)
        `CHK("first shift", cap + SIGMA, cmp)
        // Short first second puts this capture inside the high phase
        wait_sig(0, 1'b1);
        `CHK("new setting", cap + 16'(exp_phi(1, 3, -3)), cmp)
        `CHK("second new", 8'h02, idx)
        wait_sig(1, 1'b0);
        wait_sig(1, 1'b1);
        `CHK("rearmed", 1'b1, out)
    endtask
    initial begin
        do_reset(1'b0);
        test_captures();
        test_output();
        test_fall();
        close_out();
    end
endmodule // ohcr_top_tb_top
